// >>> logic/bsj_params.svh
// Constants for the buck set-point stepping and jog controller
`ifndef BSJ_PARAMS_SVH
`define BSJ_PARAMS_SVH

// Clock period and stepping timing
`define BSJ_CLK_NS 40
`define BSJ_STEP_BASE_NS 2000
`define BSJ_STEP_BASE_CYC ((`BSJ_STEP_BASE_NS + `BSJ_CLK_NS - 1) / `BSJ_CLK_NS)
`define BSJ_DLY_TICK_NS 1000
`define BSJ_DLY_TICK_CYC ((`BSJ_DLY_TICK_NS + `BSJ_CLK_NS - 1) / `BSJ_CLK_NS)
`define BSJ_CONV34_RATE 2'h1

// Register byte offsets
`define BSJ_OFS_CONV1 8'h00
`define BSJ_OFS_CONV2 8'h04
`define BSJ_OFS_CONV3 8'h08
`define BSJ_OFS_CONV4 8'h0c
`define BSJ_OFS_CTRL 8'h10
`define BSJ_OFS_STAT 8'h14

// Converter register field positions
`define BSJ_NORM_LSB 0
`define BSJ_ALT_LSB 5
`define BSJ_SLP_LSB 10
`define BSJ_RATE_LSB 15
`define BSJ_FLOOR_LSB 17
`define BSJ_CEIL_LSB 21
`define BSJ_CONV12_MASK 25'h1ffffff
`define BSJ_CONV34_MASK 25'h0007c1f

// Control register field positions
`define BSJ_CTRL_JOG_BIT 0
`define BSJ_CTRL_DLY_LSB 8

// Reset values
`define BSJ_RST_NORMAL 5'h1a
`define BSJ_RST_ALT 5'h1a
`define BSJ_RST_SLEEP 5'h1a
`define BSJ_RST_RATE 2'h1
`define BSJ_RST_FLOOR 4'h8
`define BSJ_RST_CEIL 4'ha
`define BSJ_RST_DLY 8'h00

`endif

// >>> logic/bsj_pkg.sv
// Types for the buck set-point stepping and jog controller
package bsj_pkg;
    // Edge count while a select pin is high, Gray coded along 0-1-2-3
    typedef enum logic [1:0] {
        BSJ_CNT0 = 2'b00,
        BSJ_CNT1 = 2'b01,
        BSJ_CNT2 = 2'b11,
        BSJ_CNT3 = 2'b10
    } bsj_edge_cnt_e;
    typedef logic [4:0] bsj_code_t;
endpackage

// >>> logic/bsj_step_engine.sv
// One-code-per-interval stepping engine for a single converter
`timescale 1ns/10ps
module bsj_step_engine #(
    parameter int BASE_CYC = 50,
    parameter logic [4:0] RST_CODE = 5'h1a
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Target and rate
    input wire bsj_pkg::bsj_code_t target,
    input wire logic [1:0] rate,
    // Delivered code
    output bsj_pkg::bsj_code_t code,
    output logic busy
);
    if (BASE_CYC < 1 || BASE_CYC * 8 > 1023)
    begin : g_chk
        $error("BASE_CYC out of range for the interval counter");
    end

    logic [9:0] cnt_ff;
    bsj_pkg::bsj_code_t code_ff;
    logic [9:0] lim;
    bsj_pkg::bsj_code_t last_ff;
    logic [9:0] since_ff;

    // Interval length in cycles for a rate code
    function automatic logic [9:0] interval(input logic [1:0] r);
        interval = 10'(BASE_CYC) << r;
    endfunction

    assign lim = interval(rate);
    assign busy = (code_ff != target);
    assign code = code_ff;

    // Interval counter runs only while away from target
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= 10'h000;
        else if (!busy || cnt_ff >= lim - 10'h001)
            cnt_ff <= 10'h000;
        else
            cnt_ff <= cnt_ff + 10'h001;
    end

    // One code per elapsed interval toward target, then hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            code_ff <= RST_CODE;
        else if (busy && cnt_ff >= lim - 10'h001)
        begin
            if (target > code_ff)
                code_ff <= code_ff + 5'h01;
            else
                code_ff <= code_ff - 5'h01;
        end
    end

    // Cycles since the delivered code last moved, saturating, for the spacing check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_ff <= RST_CODE;
            since_ff <= 10'h3ff;
        end
        else
        begin
            last_ff <= code_ff;
            if (code_ff != last_ff)
                since_ff <= 10'h001;
            else if (since_ff != 10'h3ff)
                since_ff <= since_ff + 10'h001;
        end
    end

    // Two moves of the delivered code are at least one interval apart
    a_step_gap: assert property (@(posedge pclk) disable iff (!presetn)
        code_ff != last_ff |-> since_ff >= lim)
        else $error("delivered code stepped before the interval ran out");
endmodule

// >>> logic/bsj_ctrl.sv
// Set-point selection, jog decoding and APB registers for four buck converters
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "bsj_params.svh"
module bsj_ctrl #(
    parameter int BASE_CYC = `BSJ_STEP_BASE_CYC,
    parameter int TICK_CYC = `BSJ_DLY_TICK_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from the processor
    input wire logic scaling_select_pin_1,
    input wire logic scaling_select_pin_2,
    input wire logic sleep_pin,
    input wire logic secondary_sleep_request,
    input wire logic spi_clk,
    // Delivered set-point codes
    output bsj_pkg::bsj_code_t delivered_code_1,
    output bsj_pkg::bsj_code_t delivered_code_2,
    output bsj_pkg::bsj_code_t delivered_code_3,
    output bsj_pkg::bsj_code_t delivered_code_4
);
    if (TICK_CYC < 1 || TICK_CYC > 31 || BASE_CYC < 4)
    begin : g_chk
        $error("TICK_CYC or BASE_CYC out of range");
    end

    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] prev_ff;
    logic [24:0] conv_ff [4];
    logic jog_en_ff;
    logic jog_en_d_ff;
    logic [7:0] dly_ff;
    logic [31:0] prdata_ff;
    logic [7:0] dly_cnt_ff;
    logic [4:0] tick_ff;
    logic sleep_eff_ff;
    logic sleep_d_ff;
    bsj_pkg::bsj_edge_cnt_e cnt_ff [2];
    bsj_pkg::bsj_code_t jog_code_ff [2];
    bsj_pkg::bsj_code_t tgt [4];
    bsj_pkg::bsj_code_t code_w [4];
    logic [1:0] rate_w [4];
    logic [3:0] busy_w;
    logic [1:0] sel;
    logic [1:0] sel_rise;
    logic [1:0] sel_fall;
    logic spi_fall;
    logic [1:0] panic;
    logic [1:0] load;
    logic wr_en;
    logic sleep_raw;

    // Mask of the implemented fields of a converter register
    function automatic logic [24:0] conv_mask(input int idx);
        conv_mask = (idx < 2) ? `BSJ_CONV12_MASK : `BSJ_CONV34_MASK;
    endfunction

    // Code field of a converter register
    function automatic bsj_pkg::bsj_code_t fld(input logic [24:0] r, input int lsb);
        fld = r[lsb +: 5];
    endfunction

    // Double-flop synchronisers: select 1, select 2, sleep, secondary, spi clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
            prev_ff <= 5'h00;
        end
        else
        begin
            sync1_ff <= {spi_clk, secondary_sleep_request, sleep_pin,
                         scaling_select_pin_2, scaling_select_pin_1};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // Edge detection on synchronised pins
    assign sel = sync2_ff[1:0];
    assign sel_rise = sync2_ff[1:0] & ~prev_ff[1:0];
    assign sel_fall = ~sync2_ff[1:0] & prev_ff[1:0];
    assign spi_fall = prev_ff[4] & ~sync2_ff[4];
    assign sleep_raw = sync2_ff[2] & sync2_ff[3];

    // APB handshake: no wait states, error on unmapped word
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr[1:0] != 2'h0 || paddr > `BSJ_OFS_STAT);
    assign wr_en = psel && penable && pwrite && !pslverr;
    assign prdata = prdata_ff;

    // Register writes; reserved and absent fields stay zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                conv_ff[i] <= conv_mask(i) & {`BSJ_RST_CEIL, `BSJ_RST_FLOOR, `BSJ_RST_RATE,
                                              `BSJ_RST_SLEEP, `BSJ_RST_ALT, `BSJ_RST_NORMAL};
            jog_en_ff <= 1'b0;
            dly_ff <= `BSJ_RST_DLY;
        end
        else if (wr_en)
        begin
            if (paddr < `BSJ_OFS_CTRL)
                conv_ff[paddr[3:2]] <= pwdata[24:0] & conv_mask(int'(paddr[3:2]));
            else if (paddr == `BSJ_OFS_CTRL)
            begin
                jog_en_ff <= pwdata[`BSJ_CTRL_JOG_BIT];
                dly_ff <= pwdata[`BSJ_CTRL_DLY_LSB +: 8];
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            if (paddr < `BSJ_OFS_CTRL)
                prdata_ff <= {7'h00, conv_ff[paddr[3:2]]};
            else if (paddr == `BSJ_OFS_CTRL)
                prdata_ff <= {16'h0000, dly_ff, 7'h00, jog_en_ff};
            else if (paddr == `BSJ_OFS_STAT)
                prdata_ff <= {3'h0, code_w[3], 3'h0, code_w[2], 3'h0, code_w[1], 3'h0, code_w[0]};
            else
                prdata_ff <= 32'h0000_0000;
        end
    end

    // Sleep entry delay in microsecond ticks; exit is immediate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dly_cnt_ff <= 8'h00;
            tick_ff <= 5'h00;
            sleep_eff_ff <= 1'b0;
        end
        else if (!sleep_raw)
        begin
            dly_cnt_ff <= 8'h00;
            tick_ff <= 5'h00;
            sleep_eff_ff <= 1'b0;
        end
        else if (dly_cnt_ff >= dly_ff)
            sleep_eff_ff <= 1'b1;
        else if (tick_ff == 5'(TICK_CYC - 1))
        begin
            tick_ff <= 5'h00;
            dly_cnt_ff <= dly_cnt_ff + 8'h01;
        end
        else
            tick_ff <= tick_ff + 5'h01;
    end

    // Previous mode and sleep, for entry and exit detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jog_en_d_ff <= 1'b0;
            sleep_d_ff <= 1'b0;
        end
        else
        begin
            jog_en_d_ff <= jog_en_ff;
            sleep_d_ff <= sleep_eff_ff;
        end
    end

    // Falling-edge count while a select pin is high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff[0] <= bsj_pkg::BSJ_CNT0;
            cnt_ff[1] <= bsj_pkg::BSJ_CNT0;
        end
        else
        begin
            for (int j = 0; j < 2; j++)
            begin
                if (sel_rise[j])
                    cnt_ff[j] <= bsj_pkg::BSJ_CNT0;
                else if (sel[j] && spi_fall)
                begin
                    unique case (cnt_ff[j])
                        bsj_pkg::BSJ_CNT0: cnt_ff[j] <= bsj_pkg::BSJ_CNT1;
                        bsj_pkg::BSJ_CNT1: cnt_ff[j] <= bsj_pkg::BSJ_CNT2;
                        bsj_pkg::BSJ_CNT2: cnt_ff[j] <= bsj_pkg::BSJ_CNT3;
                        bsj_pkg::BSJ_CNT3: cnt_ff[j] <= bsj_pkg::BSJ_CNT3;
                    endcase
                end
            end
        end
    end

    // Baseline reload and panic pulses per jog converter
    always_comb
    begin
        for (int j = 0; j < 2; j++)
        begin
            panic[j] = jog_en_ff && sel[j] && spi_fall && !sleep_eff_ff &&
                       cnt_ff[j] == bsj_pkg::BSJ_CNT2;
            load[j] = (jog_en_ff && !jog_en_d_ff) || (sleep_d_ff && !sleep_eff_ff) ||
                      (wr_en && paddr[7:2] == 6'(j));
        end
    end

    // Working copy of the normal code, moved by jog commands
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jog_code_ff[0] <= `BSJ_RST_NORMAL;
            jog_code_ff[1] <= `BSJ_RST_NORMAL;
        end
        else
        begin
            for (int j = 0; j < 2; j++)
            begin
                if (wr_en && paddr[7:2] == 6'(j))
                    jog_code_ff[j] <= pwdata[`BSJ_NORM_LSB +: 5];
                else if (load[j] || panic[j])
                    jog_code_ff[j] <= fld(conv_ff[j], `BSJ_NORM_LSB);
                else if (jog_en_ff && !sleep_eff_ff && sel_fall[j] && !busy_w[j])
                begin
                    // Stops widen with implied leading bits; commands past them drop
                    if (cnt_ff[j] == bsj_pkg::BSJ_CNT1 &&
                        jog_code_ff[j] > {1'b0, conv_ff[j][`BSJ_FLOOR_LSB +: 4]})
                        jog_code_ff[j] <= jog_code_ff[j] - 5'h01;
                    else if (cnt_ff[j] == bsj_pkg::BSJ_CNT2 &&
                             jog_code_ff[j] < {1'b1, conv_ff[j][`BSJ_CEIL_LSB +: 4]})
                        jog_code_ff[j] <= jog_code_ff[j] + 5'h01;
                end
            end
        end
    end

    // Target selection per converter
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            rate_w[i] = (i < 2) ? conv_ff[i][`BSJ_RATE_LSB +: 2] : `BSJ_CONV34_RATE;
            if (sleep_eff_ff)
                tgt[i] = fld(conv_ff[i], `BSJ_SLP_LSB);
            else if (i < 2 && jog_en_ff)
                tgt[i] = jog_code_ff[i];
            else if (i < 2 && sel[i])
                tgt[i] = fld(conv_ff[i], `BSJ_ALT_LSB);
            else
                tgt[i] = fld(conv_ff[i], `BSJ_NORM_LSB);
        end
    end

    // Stepping engines, one per converter
    for (genvar g = 0; g < 4; g++)
    begin : g_eng
        bsj_step_engine #(
            .BASE_CYC(BASE_CYC),
            .RST_CODE(`BSJ_RST_NORMAL)
        ) u_eng (
            .pclk(pclk),
            .presetn(presetn),
            .target(tgt[g]),
            .rate(rate_w[g]),
            .code(code_w[g]),
            .busy(busy_w[g])
        );
    end

    assign delivered_code_1 = code_w[0];
    assign delivered_code_2 = code_w[1];
    assign delivered_code_3 = code_w[2];
    assign delivered_code_4 = code_w[3];

    // Checks on selection, jog and stepping behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_down_req;
        jog_en_ff && !sleep_eff_ff && sel_fall[0] && !busy_w[0] && !load[0] &&
        cnt_ff[0] == bsj_pkg::BSJ_CNT1;
    endsequence

    sequence s_up_req;
        jog_en_ff && !sleep_eff_ff && sel_fall[0] && !busy_w[0] && !load[0] &&
        cnt_ff[0] == bsj_pkg::BSJ_CNT2;
    endsequence

    a_step_single: assert property ($changed(code_w[0]) |->
        (code_w[0] == 5'($past(code_w[0]) + 5'h01) || code_w[0] == 5'($past(code_w[0]) - 5'h01)))
        else $error("delivered code moved by more than one");
    a_step_spacing: assert property ($changed(code_w[0]) |=> $stable(code_w[0])[*3])
        else $error("steps closer than the interval");
    a_conv3_hold: assert property ($changed(code_w[2]) |=> !$changed(code_w[2])[*7])
        else $error("converter 3 stepped too fast");
    a_sleep_target: assert property (sleep_eff_ff |->
        tgt[2] == fld(conv_ff[2], `BSJ_SLP_LSB) && tgt[0] == fld(conv_ff[0], `BSJ_SLP_LSB))
        else $error("sleep did not select sleep code");
    a_alt_select: assert property (!jog_en_ff && !sleep_eff_ff && sel[0] |->
        tgt[0] == fld(conv_ff[0], `BSJ_ALT_LSB))
        else $error("alternate code not selected");
    a_jog_down: assert property (s_down_req ##0
        (jog_code_ff[0] > {1'b0, conv_ff[0][`BSJ_FLOOR_LSB +: 4]}) |=>
        jog_code_ff[0] == 5'($past(jog_code_ff[0]) - 5'h01))
        else $error("jog down did not lower by one");
    a_jog_ceiling: assert property (s_up_req ##0
        (jog_code_ff[0] >= {1'b1, conv_ff[0][`BSJ_CEIL_LSB +: 4]}) |=>
        $stable(jog_code_ff[0]))
        else $error("jog up passed the ceiling");
    a_panic_now: assert property (panic[0] && !load[0] |=>
        jog_code_ff[0] == fld(conv_ff[0], `BSJ_NORM_LSB))
        else $error("panic did not restore normal code");
    a_normal_kept: assert property ($changed(conv_ff[0]) |-> $past(wr_en))
        else $error("normal code changed without a write");
    a_sleep_exit: assert property (jog_en_ff && $fell(sleep_eff_ff) && !wr_en |=>
        jog_code_ff[0] == fld(conv_ff[0], `BSJ_NORM_LSB))
        else $error("sleep exit kept jog offset");
endmodule

// >>> tb/bsj_jog_host.sv
// Processor model that sends jog pulses on the select pins and serial clock
`timescale 1ns/10ps
module bsj_jog_host (
    // Select pins
    output logic scaling_select_pin_1,
    output logic scaling_select_pin_2,
    // Serial clock, idle high and still outside pulses
    output logic spi_clk
);
    // Idle levels
    initial
    begin
        scaling_select_pin_1 = 1'b0;
        scaling_select_pin_2 = 1'b0;
        spi_clk = 1'b1;
    end

    // Drive one select pin to a level
    task automatic set_select(input int unsigned which, input logic lvl);
        if (which == 1)
            scaling_select_pin_1 = lvl;
        else
            scaling_select_pin_2 = lvl;
    endtask

    // Select high, contiguous falls at 320 ns period, select low
    task automatic send_jog(input int unsigned which, input int unsigned falls);
        #7;
        set_select(which, 1'b1);
        #130;
        repeat (falls)
        begin
            spi_clk = 1'b0;
            #160;
            spi_clk = 1'b1;
            #160;
        end
        #130;
        set_select(which, 1'b0);
        #410;
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the buck set-point stepping and jog controller
`timescale 1ns/10ps
module testbench;
    localparam int BASE = 4;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} bsj_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_pin = 1'b0;
    logic secondary_sleep_request = 1'b0;
    logic sel_1;
    logic sel_2;
    logic spi_clk;
    bsj_pkg::bsj_code_t c1, c2, c3, c4;
    int err_count = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic er;
    int g;
    bsj_row_s rows[8] = '{'{8'h00, 32'h0150eb5a, 1'b0}, '{8'h04, 32'h0150eb5a, 1'b0},
        '{8'h08, 32'h0000681a, 1'b0}, '{8'h0c, 32'h0000681a, 1'b0},
        '{8'h10, 32'h00000000, 1'b0}, '{8'h14, 32'h1a1a1a1a, 1'b0},
        '{8'h18, 32'h00000000, 1'b1}, '{8'h02, 32'h00000000, 1'b1}};

    // Clock
    always #20 pclk = ~pclk;

    // Design and processor model
    bsj_ctrl #(.BASE_CYC(BASE), .TICK_CYC(2)) i_bsj_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scaling_select_pin_1(sel_1),
        .scaling_select_pin_2(sel_2), .sleep_pin(sleep_pin),
        .secondary_sleep_request(secondary_sleep_request), .spi_clk(spi_clk),
        .delivered_code_1(c1), .delivered_code_2(c2), .delivered_code_3(c3),
        .delivered_code_4(c4));
    bsj_jog_host i_bsj_jog_host (.scaling_select_pin_1(sel_1),
        .scaling_select_pin_2(sel_2), .spi_clk(spi_clk));

    // Verdict and end of run
    task automatic test_done;
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Comparisons
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_code(input bsj_pkg::bsj_code_t got, input bsj_pkg::bsj_code_t exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t code got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang(input string m);
        err_count++;
        $display("BAD %0t wait ran out: %s", $time, m);
        test_done;
    endtask

    function automatic bsj_pkg::bsj_code_t code_of(input int i);
        case (i)
            1: return c1;
            2: return c2;
            3: return c3;
            default: return c4;
        endcase
    endfunction

    // Converter 1/2 word with alternate code 5'h1d
    function automatic logic [31:0] w12(input logic [4:0] n, input logic [4:0] s,
        input logic [1:0] r, input logic [3:0] f, input logic [3:0] c);
        return {7'h00, c, f, r, s, 5'h1d, n};
    endfunction

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            hang("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk_word(rd, exp);
    endtask

    // Wait until a delivered code has been still for 80 cycles
    task automatic settle(input int i);
        int q;
        int n;
        bsj_pkg::bsj_code_t last;
        q = 0;
        n = 0;
        last = code_of(i);
        while (q < 80 && n < 4000)
        begin
            @(negedge pclk);
            q = (code_of(i) === last) ? q + 1 : 0;
            last = code_of(i);
            n++;
        end
        if (n >= 4000)
            hang("settle");
    endtask

    // Cycles between the first two changes of a delivered code
    task automatic gap(input int i);
        int n;
        bsj_pkg::bsj_code_t last;
        last = code_of(i);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (code_of(i) === last && n < 300);
        last = code_of(i);
        g = 0;
        do
        begin
            @(negedge pclk);
            g++;
        end
        while (code_of(i) === last && g < 300);
        if (g >= 300)
            hang("step");
    endtask

    task automatic jog(input int unsigned w, input int unsigned n);
        i_bsj_jog_host.send_jog(w, n);
        settle(w);
    endtask
    task automatic sleep_set(input logic p, input logic s);
        @(posedge pclk);
        sleep_pin <= p;
        secondary_sleep_request <= s;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Register table rows, then the unmapped and unaligned places
        foreach (rows[k])
        begin
            apb(1'b0, rows[k].a, 32'h00000000);
            chk_word({31'h0, er}, {31'h0, rows[k].e});
            if (!rows[k].e)
                chk_word(rd, rows[k].d); // Reset words
        end
        apb(1'b1, 8'h14, 32'h00000000);
        rd_chk(8'h14, 32'h1a1a1a1a);
        // Step interval for each rate code
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, 8'h00, w12(r[0] ? 5'h1a : 5'h16, 5'h12, r[1:0], 4'h8, 4'ha));
            gap(1);
            chk_word(32'(g), 32'(BASE << r)); // Interval
            settle(1);
        end
        apb(1'b1, 8'h08, 32'h00007017);
        apb(1'b1, 8'h0c, 32'h0000701a);
        gap(3);
        chk_word(32'(g), 32'(2 * BASE)); // Fixed interval
        settle(3);
        chk_code(c3, 5'h17);
        // Sleep needs both pins
        sleep_set(1'b1, 1'b0);
        settle(4);
        chk_code(c4, 5'h1a);
        sleep_set(1'b1, 1'b1);
        settle(4);
        chk_code(c4, 5'h1c);
        settle(1);
        chk_code(c1, 5'h12);
        sleep_set(1'b0, 1'b0);
        settle(1);
        i_bsj_jog_host.set_select(1, 1'b1);
        settle(1);
        chk_code(c1, 5'h1d); // Alternate
        chk_code(c2, 5'h1a);
        i_bsj_jog_host.set_select(1, 1'b0);
        settle(1);
        // Jog mode on converter 1, floor 5'h09, ceiling 5'h19
        apb(1'b1, 8'h00, w12(5'h19, 5'h10, 2'h3, 4'h9, 4'h9));
        apb(1'b1, 8'h10, 32'h00000001);
        settle(1);
        chk_code(c1, 5'h19);
        jog(1, 2);
        chk_code(c1, 5'h19); // At ceiling
        jog(1, 1);
        chk_code(c1, 5'h18);
        rd_chk(8'h00, w12(5'h19, 5'h10, 2'h3, 4'h9, 4'h9));
        i_bsj_jog_host.send_jog(1, 1);
        jog(1, 1);
        chk_code(c1, 5'h17); // Second dropped
        i_bsj_jog_host.send_jog(1, 1);
        jog(1, 3);
        chk_code(c1, 5'h19); // Panic while busy
        jog(1, 0);
        chk_code(c1, 5'h19); // No action
        i_bsj_jog_host.set_select(1, 1'b1);
        settle(1);
        chk_code(c1, 5'h19); // Select held high, alternate unused
        i_bsj_jog_host.set_select(1, 1'b0);
        settle(1);
        apb(1'b1, 8'h00, w12(5'h09, 5'h10, 2'h3, 4'h9, 4'h9));
        settle(1);
        chk_code(c1, 5'h09);
        jog(1, 1);
        chk_code(c1, 5'h09); // At floor
        jog(1, 2);
        chk_code(c1, 5'h0a);
        jog(2, 1);
        chk_code(c2, 5'h19);
        apb(1'b1, 8'h10, 32'h00004001); // Entry delay of 64 ticks
        sleep_set(1'b1, 1'b1);
        repeat (100) @(negedge pclk);
        chk_code(c1, 5'h0a); // Delay not yet run out
        gap(1);
        chk_word(32'(g), 32'(BASE << 3)); // Sleep steps at the register rate
        settle(1);
        chk_code(c1, 5'h10);
        sleep_set(1'b0, 1'b0);
        settle(1);
        chk_code(c1, 5'h09); // Offset dropped
        // Reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk_code(c1, 5'h1a);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'h10, 32'h00000000);
        rd_chk(8'h00, 32'h0150eb5a);
        test_done;
    end
endmodule
